// File: hw/bsid_pkg.sv
// Constants, types and carriers for the boundary-scan instruction decode block.
// Assumes a single system clock that oversamples the test-port pins.
package bsid_pkg;

    // Instruction register geometry and codes.
    localparam int IR_W = 4;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_IDCODE = 4'h2;
    localparam logic [3:0] IR_HIGHZ = 4'h4;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    // Fixed pattern loaded in Capture-IR; the two low bits must read 01.
    localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
    // Current instruction after any test-logic reset.
    localparam logic [3:0] IR_RESET_VAL = IR_IDCODE;

    // Identification register layout.
    localparam int ID_W = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam logic ID_MARKER = 1'b1;

    // Bypass stage capture value.
    localparam logic BYPASS_CAPTURE_VAL = 1'b0;

    // Depth of the pin synchroniser.
    localparam int SYNC_STAGES = 3;

    // Test-port controller states.
    typedef enum logic [3:0] {
        TAP_RESET = 4'b0000,
        TAP_IDLE = 4'b0001,
        TAP_SEL_DR = 4'b0010,
        TAP_CAP_DR = 4'b0011,
        TAP_SHIFT_DR = 4'b0100,
        TAP_EXIT1_DR = 4'b0101,
        TAP_PAUSE_DR = 4'b0110,
        TAP_EXIT2_DR = 4'b0111,
        TAP_UPD_DR = 4'b1000,
        TAP_SEL_IR = 4'b1001,
        TAP_CAP_IR = 4'b1010,
        TAP_SHIFT_IR = 4'b1011,
        TAP_EXIT1_IR = 4'b1100,
        TAP_PAUSE_IR = 4'b1101,
        TAP_EXIT2_IR = 4'b1110,
        TAP_UPD_IR = 4'b1111
    } bsid_tap_e;

    // Serial path selected between data in and data out.
    typedef enum logic [1:0] {
        PATH_BSR = 2'b00,
        PATH_ID = 2'b01,
        PATH_BYP = 2'b10
    } bsid_path_e;

    // Test-port pins as they arrive from outside the clock domain.
    typedef struct packed {
        logic trst_n;
        logic tms;
        logic tdi;
        logic tck;
    } bsid_pins_s;

    localparam bsid_pins_s PINS_RST = '{trst_n: 1'b1, tms: 1'b1, tdi: 1'b0, tck: 1'b0};

    // Serial output of the port.
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } bsid_sout_s;

endpackage

// File: hw/bsid_top.sv
// Boundary-scan test port: controller, instruction decode, data registers
// and the pin muxing that the instructions steer.
// Assumes the tester drives the test clock far slower than clock_in and that
// the core hands its pin values and enables in on the same clock.
//
// Overview of operation
// - EXTEST puts boundary register on serial path.
// - EXTEST drives loaded outputs, captures input pins.
// - IDCODE keeps functional mode, selects identification register.
// - Identification register is 32 bits, captured, shifted.
// - Identification reads never disturb functional operation.
// - After any reset, identification register selected.
// - SAMPLE/PRELOAD stays functional, samples pins, boundary path.
// - HIGH-IMPEDANCE disables every output pin.
// - HIGH-IMPEDANCE shifts through bypass, outputs stay disabled.
// - BYPASS stays functional through one-bit bypass stage.
// - Four-bit instruction codes 00,01,02,04,0F decoded.
// - Bypass stage loads zero in Capture-DR.
// - Identification fields: version, part, maker, one.
// - Controller resets by five TMS-high clocks or reset pin.
`timescale 1ns/1ps

module bsid_top
    import bsid_pkg::*;
#(
    parameter int NUM_IN = 8,
    parameter int NUM_OUT = 8,
    parameter logic [3:0] ID_VERSION = 4'h0,
    // Arbitrary value, not a real part number.
    parameter logic [15:0] ID_PART = 16'h0abc,
    // Arbitrary value, not a real maker code.
    parameter logic [10:0] ID_MFR = 11'h055
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire bsid_pins_s pins_in,
    output bsid_sout_s sout_out,
    input wire logic [NUM_OUT-1:0] core_out_in,
    input wire logic [NUM_OUT-1:0] core_oe_in,
    output logic [NUM_OUT-1:0] pin_out,
    output logic [NUM_OUT-1:0] pin_oe_out,
    input wire logic [NUM_IN-1:0] pin_in,
    output logic [NUM_IN-1:0] core_in_out,
    output logic [IR_W-1:0] ir_out
);

    // Boundary chain: input cells low, then one enable cell, outputs high.
    localparam int BSR_LEN = NUM_IN + 1 + NUM_OUT;
    localparam int OE_CELL = NUM_IN;

    generate
        if (NUM_IN < 1 || NUM_OUT < 1) begin : g_bad_size
            $error("bsid_top needs at least one input and one output cell.");
        end
    endgenerate

    // Pin synchroniser; the filtered level moves only when stages two and three agree.
    bsid_pins_s sync1_q, sync2_q, sync3_q, filt_q, filt_d;
    logic tck_prev_q;
    logic tck_rise, tck_fall;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sync1_q <= PINS_RST;
            sync2_q <= PINS_RST;
            sync3_q <= PINS_RST;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Agreement filter: a bit changes only when both late stages hold the new level.
    always_comb begin
        filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            filt_q <= PINS_RST;
            tck_prev_q <= 1'b0;
        end else begin
            filt_q <= filt_d;
            tck_prev_q <= filt_q.tck;
        end
    end

    // TMS and TDI pass the same filter as TCK, so they stay aligned to its edges.
    assign tck_rise = filt_q.tck & ~tck_prev_q;
    assign tck_fall = ~filt_q.tck & tck_prev_q;

    // Controller state, stepped on each filtered rising test-clock edge.
    bsid_tap_e tap_q, tap_d;

    always_comb begin
        case (tap_q)
            TAP_RESET: tap_d = filt_q.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_d = filt_q.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_d = filt_q.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_d = filt_q.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_d = filt_q.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_d = filt_q.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_d = filt_q.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_d = filt_q.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_d = filt_q.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_d = filt_q.tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_d = filt_q.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_d = filt_q.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_d = filt_q.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_d = filt_q.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_d = filt_q.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_d = filt_q.tms ? TAP_SEL_DR : TAP_IDLE;
            default: tap_d = TAP_RESET;
        endcase
    end

    // reset pin or TMS walk
    // The state walk guarantees five TMS-high edges land in reset from anywhere.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tap_q <= TAP_RESET;
        end else if (!filt_q.trst_n) begin
            tap_q <= TAP_RESET;
        end else if (tck_rise) begin
            tap_q <= tap_d;
        end
    end

    // Instruction shift stage and the current (latched) instruction.
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;

    // Capture loads the fixed pattern; shifting enters TDI at the top.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ir_sh_q <= IR_CAPTURE_VAL;
        end else if (tck_rise && tap_q == TAP_CAP_IR) begin
            ir_sh_q <= IR_CAPTURE_VAL;
        end else if (tck_rise && tap_q == TAP_SHIFT_IR) begin
            ir_sh_q <= {filt_q.tdi, ir_sh_q[IR_W-1:1]};
        end
    end

    // latch only at Update-IR
    // Shifting never touches ir_q, so the old instruction rules until the falling edge in Update-IR.
    always_ff @(posedge clock_in) begin
        if (srst_in || !filt_q.trst_n) begin
            ir_q <= IR_RESET_VAL;
        end else if (tap_q == TAP_RESET) begin
            ir_q <= IR_RESET_VAL;
        end else if (tck_fall && tap_q == TAP_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // Decode of the current instruction into path and pin mode.
    bsid_path_e path;
    logic mode_extest;
    logic mode_highz;

    always_comb begin
        mode_extest = 1'b0;
        mode_highz = 1'b0;
        case (ir_q)
            IR_EXTEST: begin
                path = PATH_BSR;
                mode_extest = 1'b1;
            end
            IR_SAMPLE: path = PATH_BSR;
            IR_IDCODE: path = PATH_ID;
            IR_HIGHZ: begin
                path = PATH_BYP;
                mode_highz = 1'b1;
            end
            IR_BYPASS: path = PATH_BYP;
            default: path = PATH_BYP;
        endcase
    end

    // Data registers: bypass stage, identification and boundary chain.
    logic byp_q;
    logic [ID_W-1:0] id_q;
    logic [BSR_LEN-1:0] bsr_q;
    logic [BSR_LEN-1:0] bsr_upd_q;
    logic [ID_W-1:0] id_value;
    logic [BSR_LEN-1:0] bsr_capture;

    always_comb begin
        id_value = '0;
        id_value[ID_W-1:ID_VER_LSB] = ID_VERSION;
        id_value[ID_VER_LSB-1:ID_PART_LSB] = ID_PART;
        id_value[ID_PART_LSB-1:ID_MFR_LSB] = ID_MFR;
        id_value[0] = ID_MARKER;
    end

    // capture pins and core values
    // Outputs capture what the core presents, inputs what the pins carry.
    assign bsr_capture = {core_out_in, (|core_oe_in), pin_in};

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            byp_q <= BYPASS_CAPTURE_VAL;
        end else if (tck_rise && path == PATH_BYP) begin
            if (tap_q == TAP_CAP_DR) begin
                byp_q <= BYPASS_CAPTURE_VAL;
            end else if (tap_q == TAP_SHIFT_DR) begin
                byp_q <= filt_q.tdi;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            id_q <= '0;
        end else if (tck_rise && path == PATH_ID) begin
            if (tap_q == TAP_CAP_DR) begin
                id_q <= id_value;
            end else if (tap_q == TAP_SHIFT_DR) begin
                id_q <= {filt_q.tdi, id_q[ID_W-1:1]};
            end
        end
    end

    // preload via boundary chain
    // The update latch keeps SAMPLE/PRELOAD contents, so EXTEST starts from them.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            bsr_q <= '0;
        end else if (tck_rise && path == PATH_BSR) begin
            if (tap_q == TAP_CAP_DR) begin
                bsr_q <= bsr_capture;
            end else if (tap_q == TAP_SHIFT_DR) begin
                bsr_q <= {filt_q.tdi, bsr_q[BSR_LEN-1:1]};
            end
        end
    end

    // Update latch of the boundary chain, loaded on the falling edge in Update-DR.
    always_ff @(posedge clock_in) begin
        if (srst_in || !filt_q.trst_n) begin
            bsr_upd_q <= '0;
        end else if (tck_fall && tap_q == TAP_UPD_DR && path == PATH_BSR) begin
            bsr_upd_q <= bsr_q;
        end
    end

    // Serial output: changes on the falling test-clock edge, enabled only while shifting.
    logic tdo_d;
    logic shifting;

    always_comb begin
        case (path)
            PATH_BSR: tdo_d = bsr_q[0];
            PATH_ID: tdo_d = id_q[0];
            PATH_BYP: tdo_d = byp_q;
            default: tdo_d = byp_q;
        endcase
        if (tap_q == TAP_SHIFT_IR) begin
            tdo_d = ir_sh_q[0];
        end
    end

    assign shifting = (tap_q == TAP_SHIFT_IR) || (tap_q == TAP_SHIFT_DR);

    always_ff @(posedge clock_in) begin
        if (srst_in || !filt_q.trst_n) begin
            sout_out <= '0;
        end else if (tck_fall) begin
            sout_out.tdo <= shifting ? tdo_d : 1'b0;
            sout_out.tdo_oe <= shifting;
        end
    end

    // Pin drive. Outputs are registered so that they are glitch-free off the decode.
    logic [NUM_OUT-1:0] pin_d;
    logic [NUM_OUT-1:0] pin_oe_d;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            always_comb begin
                if (mode_highz) begin
                    pin_d[gi] = 1'b0;
                    pin_oe_d[gi] = 1'b0;
                end else if (mode_extest) begin
                    pin_d[gi] = bsr_upd_q[NUM_IN+1+gi];
                    pin_oe_d[gi] = bsr_upd_q[OE_CELL];
                end else begin
                    pin_d[gi] = core_out_in[gi];
                    pin_oe_d[gi] = core_oe_in[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pin_out <= '0;
            pin_oe_out <= '0;
        end else begin
            pin_out <= pin_d;
            pin_oe_out <= pin_oe_d;
        end
    end

    // Core inputs follow the pins; during EXTEST the core sees the tester's
    // stimulus, a limitation accepted to keep the input path free of muxes.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            core_in_out <= '0;
            ir_out <= IR_RESET_VAL;
        end else begin
            core_in_out <= pin_in;
            ir_out <= ir_q;
        end
    end

endmodule // bsid_top

// File: sim/bsid_top_sva.sv
// Checker for the boundary-scan port; it sees only the top-level ports.
// Assumes the bench binds it and keeps test clock phases many cycles long.
`timescale 1ns/1ps
module bsid_top_sva
    import bsid_pkg::*;
#(
    parameter int NUM_IN = 8,
    parameter int NUM_OUT = 8
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire bsid_pins_s pins_in,
    input wire bsid_sout_s sout_out,
    input wire logic [NUM_OUT-1:0] core_out_in,
    input wire logic [NUM_OUT-1:0] core_oe_in,
    input wire logic [NUM_OUT-1:0] pin_out,
    input wire logic [NUM_OUT-1:0] pin_oe_out,
    input wire logic [NUM_IN-1:0] pin_in,
    input wire logic [NUM_IN-1:0] core_in_out,
    input wire logic [IR_W-1:0] ir_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // An instruction that has already held for one cycle, clear of reset.
    sequence s_ir_held(logic [3:0] code);
        ir_out == code && $stable(ir_out) && !$past(srst_in);
    endsequence
    // The reset pin held low long enough to pass the pin filter.
    sequence s_trst_low;
        (!pins_in.trst_n) [*8];
    endsequence
    // Functional codes; the pins lag the decode by one clock.
    sequence s_func;
        !$past(srst_in) && $stable(ir_out) && ir_out != IR_EXTEST && ir_out != IR_HIGHZ;
    endsequence
    a_highz_all_off: assert property (s_ir_held(IR_HIGHZ) |-> pin_oe_out == '0)
        else $error("outputs enabled in high impedance");
    a_extest_one_enable: assert property (s_ir_held(IR_EXTEST) |-> (&pin_oe_out) || !(|pin_oe_out))
        else $error("output enables differ in external test");
    a_func_value_pass: assert property (s_func |-> pin_out == $past(core_out_in))
        else $error("core value not passed to pin");
    a_func_enable_pass: assert property (s_func |-> pin_oe_out == $past(core_oe_in))
        else $error("core enable not passed to pin");
    a_core_in_pipe: assert property (!$past(srst_in) |-> core_in_out == $past(pin_in))
        else $error("input pin not passed to core");
    a_reset_to_id: assert property (disable iff (1'b0) srst_in |=> ir_out == IR_RESET_VAL && sout_out == '0)
        else $error("reset did not select identification");
    a_trst_to_id: assert property (s_trst_low |=> ir_out == IR_IDCODE && !sout_out.tdo_oe)
        else $error("reset pin did not select identification");
    a_ir_after_fall: assert property ($changed(ir_out) |-> ir_out == IR_IDCODE || !pins_in.tck)
        else $error("instruction changed outside update");
    a_tdo_after_fall: assert property ($changed(sout_out) |-> !pins_in.tck)
        else $error("serial output moved while test clock high");
endmodule // bsid_top_sva

// File: sim/bsid_tester.sv
// Tester model: one test clock period of 80 ns per step request, serial
// output sampled at the rising edge. Assumes requests only while idle.
`timescale 1ns/1ps
module bsid_tester
    import bsid_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic step_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic trst_n_in,
    input wire bsid_sout_s sout_in,
    output bsid_pins_s pins_out,
    output logic tdo_out,
    output logic busy_out
);
    logic [4:0] cnt_q;
    logic tck_q;
    logic tms_q;
    logic tdi_q;
    // Pin bundle; the test clock rests low between steps.
    assign pins_out = '{trst_n: trst_n_in, tms: tms_q, tdi: tdi_q, tck: tck_q};
    // Eight cycles low in a step plus two idle cycles between steps, then ten high:
    // an 80 ns test clock. TMS and TDI change only while the clock is low.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cnt_q <= 5'h00;
            tck_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b0;
            busy_out <= 1'b0;
        end else if (busy_out) begin
            cnt_q <= cnt_q + 5'h01;
            tck_q <= (cnt_q >= 5'h07) && (cnt_q != 5'h11);
            busy_out <= (cnt_q != 5'h11);
        end else if (step_in) begin
            cnt_q <= 5'h00;
            busy_out <= 1'b1;
            tms_q <= tms_in;
            tdi_q <= tdi_in;
        end else begin
            // Data is meaningless between steps, so it must not look steady.
            tdi_q <= ~tdi_q;
        end
    end
    // Sample the serial output at the rising test clock edge. A released line reads
    // as the inverse of its level, so an enable that drops early shows as a bad bit.
    always_ff @(posedge clock_in) begin
        if (busy_out && cnt_q == 5'h07) begin
            tdo_out <= sout_in.tdo_oe ? sout_in.tdo : ~sout_in.tdo;
        end
    end
endmodule // bsid_tester

// File: sim/test_bsid_top.sv
// Bench: walks every instruction code through the tester model and checks
// chains, pins and resets. Assumes the tester model and the checker file.
`timescale 1ns/1ps
module test_bsid_top;
    import bsid_pkg::*;
    localparam int NI = 8;
    localparam int NO = 8;
    // Arbitrary identification fields.
    localparam logic [3:0] VER = 4'h5;
    localparam logic [15:0] PART = 16'h2c71;
    localparam logic [10:0] MFR = 11'h1d3;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic step = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b0;
    logic trst_n = 1'b1;
    logic tdo;
    logic busy;
    bsid_pins_s pins;
    bsid_sout_s sout;
    logic [NO-1:0] core_out = '0;
    logic [NO-1:0] core_oe = '0;
    logic [NI-1:0] pin_v = '0;
    logic [NO-1:0] pin_out;
    logic [NO-1:0] pin_oe;
    logic [IR_W-1:0] ir;
    logic [3:0] cur_ir = IR_IDCODE;
    logic [16:0] upd = '0;
    int mismatches = 0;
    int compares = 0;
    int seed = 36;
    always #2 clock_in = ~clock_in;
    bsid_top #(.NUM_IN(NI), .NUM_OUT(NO), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) bsid_top_inst (
        .clock_in(clock_in), .srst_in(srst_in), .pins_in(pins), .sout_out(sout), .core_out_in(core_out),
        .core_oe_in(core_oe), .pin_out(pin_out), .pin_oe_out(pin_oe), .pin_in(pin_v), .core_in_out(),
        .ir_out(ir));
    bsid_tester bsid_tester_inst (.clock_in(clock_in), .rst_in(srst_in), .step_in(step), .tms_in(tms),
        .tdi_in(tdi), .trst_n_in(trst_n), .sout_in(sout), .pins_out(pins), .tdo_out(tdo), .busy_out(busy));
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic bad(input string what);
        mismatches++;
        $display("wrong value at %0t: %s", $time, what);
    endtask
    task automatic cmp_ir(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) bad($sformatf("instruction %h not %h", got, exp));
    endtask
    task automatic cmp_chain(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) bad($sformatf("chain %h not %h", got, exp));
    endtask
    task automatic cmp_pins(input logic [NO-1:0] got, input logic [NO-1:0] exp);
        compares++;
        if (got !== exp) bad($sformatf("pins %h not %h", got, exp));
    endtask
    // Expected serial output: captured word first, then the data shifted in.
    function automatic logic [39:0] exp_dr(input logic [3:0] c, input logic [39:0] d);
        logic [39:0] cap;
        int len;
        cap = 40'h0;
        len = 1;
        if (c == IR_IDCODE) begin
            cap = {8'h00, VER, PART, MFR, ID_MARKER};
            len = 32;
        end
        if (c == IR_EXTEST || c == IR_SAMPLE) begin
            cap = {23'h0, core_out, |core_oe, pin_v};
            len = NI + 1 + NO;
        end
        return (d << len) | cap;
    endfunction
    // One test clock step through the tester model.
    task automatic tick(input logic m, input logic d, output logic o);
        int n;
        @(negedge clock_in);
        tms = m;
        tdi = d;
        step = 1'b1;
        @(negedge clock_in);
        step = 1'b0;
        n = 0;
        while (busy && n < 100) begin
            @(negedge clock_in);
            n++;
        end
        if (n >= 100) bad("tester step did not finish");
        o = tdo;
    endtask
    task automatic ir_scan(input logic [3:0] code);
        logic [3:0] o4;
        logic o;
        tick(1'b1, 1'b0, o);
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < 4; i++) tick(i == 3, code[i], o4[i]);
        cmp_ir(ir, cur_ir);
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        cmp_ir(o4, IR_CAPTURE_VAL);
        cur_ir = code;
        cmp_ir(ir, code);
    endtask
    // Data scan of 40 bits from idle, ending back in idle.
    task automatic dr_scan();
        logic [39:0] din;
        logic [39:0] dout;
        logic o;
        din = {8'($random(seed)), 32'($random(seed))};
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < 40; i++) tick(i == 39, din[i], dout[i]);
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        cmp_chain(dout, exp_dr(cur_ir, din));
        if (cur_ir == IR_EXTEST || cur_ir == IR_SAMPLE) upd = din[39:23];
    endtask
    task automatic pin_check();
        if (cur_ir == IR_EXTEST) begin
            cmp_pins(pin_out, upd[16:9]);
            cmp_pins(pin_oe, {NO{upd[8]}});
        end else if (cur_ir == IR_HIGHZ) begin
            cmp_pins(pin_oe, '0);
            cmp_pins(pin_out, '0);
        end else begin
            cmp_pins(pin_out, core_out);
            cmp_pins(pin_oe, core_oe);
        end
    endtask
    // Main sequence; SAMPLE runs first so EXTEST starts from preloaded values.
    initial begin
        logic o;
        repeat (5) @(negedge clock_in);
        srst_in = 1'b0;
        repeat (6) @(negedge clock_in);
        repeat (5) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        dr_scan();
        for (int i = 0; i < 16; i++) begin
            core_out = NO'($random(seed));
            core_oe = NO'($random(seed));
            pin_v = NI'($random(seed));
            ir_scan(4'(i) ^ {3'h0, i < 2});
            pin_check();
            dr_scan();
            pin_check();
        end
        @(negedge clock_in);
        trst_n = 1'b0;
        repeat (40) @(negedge clock_in);
        cmp_ir(ir, IR_IDCODE);
        trst_n = 1'b1;
        repeat (20) @(negedge clock_in);
        cur_ir = IR_IDCODE;
        tick(1'b0, 1'b0, o);
        dr_scan();
        results();
    end
    // Watchdog well beyond the expected run of about 80 us, yet under 100,000 clocks.
    initial begin
        #300000;
        bad("watchdog expired");
        results();
    end
endmodule // test_bsid_top
bind bsid_top bsid_top_sva #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) bsid_top_sva_inst (.clock_in(clock_in),
    .srst_in(srst_in), .pins_in(pins_in), .sout_out(sout_out), .core_out_in(core_out_in), .core_oe_in(core_oe_in),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pin_in(pin_in), .core_in_out(core_in_out), .ir_out(ir_out));
